// ### hw/hpsp_port.v
// Purpose: Host parallel slave port, device side
// Assumes: Host strobes asynchronous to core_clk, synchronised here
// Notes: Read data FIFO feeds host; host writes go to user port
`include "hpsp_defs.vh"
`timescale 1ns/10ps
module hpsp_port #(
    parameter DW = `HPSP_DATA_W,
    parameter DEPTH = `HPSP_FIFO_DEPTH,
    parameter AW = 3
)
(
    input wire core_clk,
    input wire rst,
    input wire hostSelectN,
    input wire hostReadN,
    input wire hostWriteN,
    input wire transferTypeSelect,
    input wire transferModeSelect,
    input wire [7:0] hostDataLowByteIn,
    input wire [7:0] hostDataHighByteIn,
    output reg [7:0] hostDataLowByteOut,
    output reg [7:0] hostDataHighByteOut,
    output reg hostDataLowByteOe,
    output reg hostDataHighByteOe,
    output reg hostIrq,
    output reg transferReadyFlag,
    input wire txValid,
    output wire txReady,
    input wire [DW-1:0] txData,
    input wire [DW-1:0] statusWord,
    output reg rxDataValid,
    output reg rxCtrlValid,
    output reg rxFast,
    output reg [DW-1:0] rxWord,
    output reg [DW-1:0] statusOut
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg [2:0] meta_r;
    reg [2:0] sync_r;
    reg [1:0] modeMeta_r;
    reg [1:0] modeSync_r;
    reg [7:0] lowMeta_r;
    reg [7:0] lowSync_r;
    reg [7:0] highMeta_r;
    reg [7:0] highSync_r;
    reg selPrev_r;
    reg rdPrev_r;
    reg wrPrev_r;
    always @(posedge core_clk)
    begin
        meta_r <= {hostSelectN, hostReadN, hostWriteN};
        sync_r <= meta_r;
        modeMeta_r <= {transferModeSelect, transferTypeSelect};
        modeSync_r <= modeMeta_r;
        lowMeta_r <= hostDataLowByteIn;
        lowSync_r <= lowMeta_r;
        highMeta_r <= hostDataHighByteIn;
        highSync_r <= highMeta_r;
    end
    wire selN = sync_r[2];
    wire rdN = sync_r[1];
    wire wrN = sync_r[0];
    wire fastMode = modeSync_r[1];
    wire typeSel = modeSync_r[0] & ~fastMode;
    wire readAct = !selN && !rdN;
    wire readStart = readAct && (rdPrev_r || selPrev_r);
    wire readEnd = !readAct && !(rdPrev_r || selPrev_r);
    wire writeDone = wrN && !wrPrev_r && !selN;
    // ------------------------------------------------------------
    // Outgoing data FIFO
    // ------------------------------------------------------------
    wire fifoValid;
    wire [DW-1:0] fifoData;
    wire popData = readStart && (fastMode || !typeSel);
    hpsp_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(txValid),
        .inReady(txReady),
        .inData(txData),
        .outValid(fifoValid),
        .outReady(popData),
        .outData(fifoData)
    );
    // ------------------------------------------------------------
    // Read path and strobes
    // ------------------------------------------------------------
    reg [DW-1:0] readWord;
    reg [1:0] rdyCnt_r;
    always @*
    begin
        if (!fastMode && typeSel)
        begin
            readWord = statusWord;
        end
        else
        begin
            readWord = fifoValid ? fifoData : {DW{1'b0}};
        end
    end
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            selPrev_r <= 1'b1;
            rdPrev_r <= 1'b1;
            wrPrev_r <= 1'b1;
            hostDataLowByteOut <= 8'h00;
            hostDataHighByteOut <= 8'h00;
            hostDataLowByteOe <= 1'b0;
            hostDataHighByteOe <= 1'b0;
            hostIrq <= 1'b0;
            transferReadyFlag <= 1'b1;
            rdyCnt_r <= 2'b00;
            rxDataValid <= 1'b0;
            rxCtrlValid <= 1'b0;
            rxFast <= 1'b0;
            rxWord <= {DW{1'b0}};
            statusOut <= `HPSP_STATUS_RST;
        end
        else
        begin
            selPrev_r <= selN;
            rdPrev_r <= rdN;
            wrPrev_r <= wrN;
            rxDataValid <= 1'b0;
            rxCtrlValid <= 1'b0;
            statusOut <= {{(DW-3){1'b0}}, fastMode, !hostIrq, fifoValid};
            if (readStart)
            begin
                hostDataLowByteOut <= readWord[7:0];
                hostDataHighByteOut <= readWord[15:8];
                hostDataLowByteOe <= 1'b1;
                hostDataHighByteOe <= fastMode;
            end
            else if (!readAct)
            begin
                hostDataLowByteOe <= 1'b0;
                hostDataHighByteOe <= 1'b0;
            end
            if (readAct)
            begin
                hostIrq <= 1'b0;
            end
            else
            begin
                hostIrq <= !fastMode && fifoValid;
            end
            if (writeDone)
            begin
                rxWord <= fastMode ? {highSync_r, lowSync_r}
                                   : {8'h00, lowSync_r};
                rxDataValid <= fastMode || !typeSel;
                rxCtrlValid <= !fastMode && typeSel;
                rxFast <= fastMode;
            end
            if (readStart || (!wrN && !selN))
            begin
                transferReadyFlag <= 1'b0;
                rdyCnt_r <= `HPSP_READY_HOLD;
            end
            else if (readEnd || writeDone || rdyCnt_r != 2'b00)
            begin
                if (rdyCnt_r != 2'b00)
                begin
                    rdyCnt_r <= rdyCnt_r - 2'b01;
                end
                transferReadyFlag <= (rdyCnt_r <= 2'b01) && !readAct
                                     && (wrN || selN);
            end
        end
    end
endmodule

// ### hw/hpsp_defs.vh
// Purpose: Constants for the host parallel slave port
// Assumes: Included by hw/hpsp_port.v; hw/hpsp_fifo.v does not include it
// Notes: Behaviour list below
//
// Behaviour
// - Drive data bus only during select and read
// - Select plus write strobe makes bus input
// - Decode word by address and mode inputs
// - Capture write word at write strobe rise
// - Present read word when read strobe falls
// - Mode 0: raise request while data pending
// - Host read access clears the request
// - Mode 0: type input picks data/status/control
// - Mode 1: ignore the type input
// - Strobes ignored while select is high
// - Mode input low control, high fast
// - Mode 1: ready flag shows access status
// - Upper byte used only in fast mode
`ifndef HPSP_DEFS_VH
`define HPSP_DEFS_VH
`define HPSP_DATA_W 16
`define HPSP_FIFO_DEPTH 8
`define HPSP_STATUS_RST 16'h0000
`define HPSP_STAT_TXVALID 0
`define HPSP_STAT_RXREADY 1
`define HPSP_STAT_MODE 2
`define HPSP_READY_HOLD 2'h2
`endif

// ### hw/hpsp_fifo.v
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth must be a power of two
`timescale 1ns/10ps
module hpsp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    input wire core_clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_r;
    reg [AW:0] rdPtr_r;
    wire full;
    wire empty;
    assign empty = (wrPtr_r == rdPtr_r);
    assign full = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) &&
                  (wrPtr_r[AW] != rdPtr_r[AW]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_r[AW-1:0]];
    always @(posedge core_clk)
    begin
        if (inValid && !full)
        begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (inValid && !full)
            begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (outReady && !empty)
            begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule

// ### test/hpsp_host.sv
// Purpose: Host bus master model for the parallel port
// Assumes: Pins change 1 ns after core_clk rises
// Notes: Bus not driven by host shows inverted last value
`timescale 1ns/10ps
module hpsp_host (
    input wire core_clk,
    input wire rdyFlag,
    input wire [15:0] pin,
    output logic selN,
    output logic rdN,
    output logic wrN,
    output logic typ,
    output logic mode,
    output logic [15:0] drv
);
    initial {selN, rdN, wrN, typ, mode, drv} = {3'h7, 2'h0, 16'h0000};
    task xfer(input ns, input w, input m, input t, input [15:0] d,
        output [15:0] q);
        int i;
        begin
            i = 0;
            mode = m;
            typ = t;
            while (m && !rdyFlag && i < 40)
            begin
                @(posedge core_clk);
                #1 i++;
            end
            selN = ns;
            drv = w ? d : ~drv;
            if (w) wrN = 0;
            else rdN = 0;
            repeat (6) @(posedge core_clk);
            q = pin;
            #1 rdN = 1;
            wrN = 1;
            repeat (5) @(posedge core_clk);
            #1 selN = 1;
            drv = ~drv;
            repeat (6) @(posedge core_clk);
            #1;
        end
    endtask
endmodule

// ### test/hpsp_port_sva.sv
// Purpose: Port checker for the parallel host port
// Assumes: Host holds strobes at least 6 cycles
// Notes: Bound to hpsp_port
`timescale 1ns/10ps
module hpsp_port_sva #(parameter DW = 16) (
    input wire core_clk,
    input wire rst,
    input wire hostSelectN,
    input wire hostReadN,
    input wire hostWriteN,
    input wire transferModeSelect,
    input wire hostDataLowByteOe,
    input wire hostDataHighByteOe,
    input wire hostIrq,
    input wire transferReadyFlag,
    input wire rxDataValid,
    input wire rxCtrlValid,
    input wire rxFast,
    input wire [DW-1:0] rxWord
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_oe_on_read: assert property ($rose(hostDataLowByteOe) |->
        $past(!hostSelectN && !hostReadN, 2)) else $error("oe w/o read");
    a_high_fast: assert property (hostDataHighByteOe |->
        hostDataLowByteOe && $past(transferModeSelect, 3))
        else $error("high byte outside fast mode");
    a_bus_release: assert property ((hostSelectN || hostReadN) [*7] |->
        !hostDataLowByteOe && !hostDataHighByteOe) else $error("bus held");
    a_irq_clear: assert property ((!hostSelectN && !hostReadN) [*5] |->
        !hostIrq) else $error("irq kept during read");
    a_ready_idle: assert property ((hostReadN && hostWriteN) [*8] |->
        transferReadyFlag) else $error("ready not back");
    a_ready_busy: assert property ((!hostSelectN && !hostWriteN &&
        transferModeSelect) [*6] |-> !transferReadyFlag)
        else $error("ready during write");
    a_write_cause: assert property (rxDataValid || rxCtrlValid |->
        $past(!hostSelectN && hostWriteN, 2) && $past(!hostWriteN, 6))
        else $error("rx pulse w/o write");
    a_ctrl_mode0: assert property (rxCtrlValid |-> !rxFast)
        else $error("control word in fast mode");
    a_narrow_word: assert property (rxDataValid && !rxFast |->
        rxWord[DW-1:8] == 8'h00) else $error("upper byte in mode 0");
    a_unselected: assert property (hostSelectN [*8] |->
        !hostDataLowByteOe && !rxDataValid && !rxCtrlValid)
        else $error("activity while unselected");
    c_read: cover property ($rose(hostDataLowByteOe));
    c_ctrl: cover property (rxCtrlValid);
    c_irq: cover property ($fell(hostIrq));
endmodule
bind hpsp_port hpsp_port_sva #(.DW(DW)) u_sva (.core_clk(core_clk),
    .rst(rst), .hostSelectN(hostSelectN), .hostReadN(hostReadN),
    .hostWriteN(hostWriteN), .transferModeSelect(transferModeSelect),
    .hostDataLowByteOe(hostDataLowByteOe), .hostIrq(hostIrq),
    .hostDataHighByteOe(hostDataHighByteOe), .rxFast(rxFast),
    .transferReadyFlag(transferReadyFlag), .rxDataValid(rxDataValid),
    .rxCtrlValid(rxCtrlValid), .rxWord(rxWord));

// ### test/hpsp_port_tb.sv
// Purpose: Self-checking bench for hpsp_port
// Assumes: Host model drives the pins
// Notes: Inputs change 1 ns after core_clk rises
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", n, e, a); end end
module hpsp_port_tb;
    logic core_clk = 0, rst = 1, txValid = 0, rxKind, rxFastL;
    logic [15:0] txData = 0, statusWord = 16'h5a3c, rxLast, q;
    wire selN, rdN, wrN, typ, mode, loOe, hiOe, irq, rdy, txReady;
    wire rxD, rxC, rxF;
    wire [15:0] drv, pin, rxWord, stOut;
    wire [7:0] loOut, hiOut;
    int err_total = 0, compares = 0, rxCnt = 0, i, n;
    always #4 core_clk = ~core_clk;
    assign pin = {hiOe ? hiOut : drv[15:8], loOe ? loOut : drv[7:0]};
    always @(negedge core_clk)
        if (rxD || rxC)
        begin
            rxCnt++;
            {rxLast, rxKind, rxFastL} = {rxWord, rxC, rxF};
        end
    hpsp_host h (.core_clk(core_clk), .rdyFlag(rdy), .pin(pin),
        .selN(selN), .rdN(rdN), .wrN(wrN), .typ(typ), .mode(mode),
        .drv(drv));
    hpsp_port DUT (.core_clk(core_clk), .rst(rst), .hostSelectN(selN),
        .hostReadN(rdN), .hostWriteN(wrN), .transferTypeSelect(typ),
        .transferModeSelect(mode), .hostDataLowByteIn(pin[7:0]),
        .hostDataHighByteIn(pin[15:8]), .hostDataLowByteOut(loOut),
        .hostDataHighByteOut(hiOut), .hostDataLowByteOe(loOe),
        .hostDataHighByteOe(hiOe), .hostIrq(irq),
        .transferReadyFlag(rdy), .txValid(txValid), .txReady(txReady),
        .txData(txData), .statusWord(statusWord), .rxDataValid(rxD),
        .rxCtrlValid(rxC), .rxFast(rxF), .rxWord(rxWord),
        .statusOut(stOut));
    task push(input [15:0] d);
        begin
            {txValid, txData} = {1'b1, d};
            @(posedge core_clk);
            #1 txValid = 0;
            @(posedge core_clk);
            #1;
        end
    endtask
    task t_mode0;
        begin
            push(16'hbeef);
            repeat (6) @(posedge core_clk);
            `CHK("irq", 1'b1, irq)
            `CHK("status out", 16'h0001, stOut)
            h.xfer(0, 0, 0, 0, 0, q);
            `CHK("data", 8'hef, q[7:0])
            `CHK("irq", 1'b0, irq)
            h.xfer(0, 0, 0, 1, 0, q);
            `CHK("status", statusWord[7:0], q[7:0])
        end
    endtask
    task t_fifo;
        begin
            for (i = 0; txReady && i < 12; i++) push(16'h1234 ^ 16'(i));
            `CHK("fill", 8, i)
            for (i = 0; i < 9; i++)
            begin
                h.xfer(0, 0, 1, 1, 0, q);
                `CHK("fast", i < 8 ? 16'h1234 ^ 16'(i) : 16'h0000, q)
            end
        end
    endtask
    task t_write;
        for (i = 0; i < 4; i++)
        begin
            n = rxCnt;
            h.xfer(0, 1, i[1], i[0], 16'hc35a ^ 16'(i), q);
            `CHK("count", n + 1, rxCnt)
            `CHK("kind", !i[1] && i[0], rxKind)
            `CHK("fast", i[1], rxFastL)
            `CHK("word", (16'hc35a ^ 16'(i)) & (i[1] ? 16'hffff : 16'h00ff),
                rxLast)
        end
    endtask
    task t_unsel;
        begin
            n = rxCnt;
            h.xfer(1, 1, 0, 0, 16'h0f0f, q);
            h.xfer(1, 0, 0, 1, 0, q);
            `CHK("unselected", n, rxCnt)
        end
    endtask
    task print_verdict;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial
    begin
        #60000 err_total++;
        print_verdict;
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        #1 rst = 0;
        repeat (4) @(posedge core_clk);
        #1 t_mode0;
        t_fifo;
        t_write;
        t_unsel;
        print_verdict;
    end
endmodule
